// ==== hdl/cspc_clock_control.sv ====
// Clock source selection, PLL enable and switch-over, core divider, clock output and tuning.
// Assumes oscillator, PLL and pin levels are synchronous to clk_sys and an APB3 master.
`timescale 1ns/1ps
`default_nettype none
module cspc_clock_control #(
  parameter int START_EDGES = cspc_pkg::CRYSTAL_START_EDGES,
  parameter int TUNE_STEP = cspc_pkg::TUNE_STEP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clockInPin,
  input wire logic fastOscClk,
  input wire logic slowRcClk,
  input wire logic pllClk,
  input wire logic pllLocked,
  input wire logic sleepMode,
  output logic pllEnable,
  output logic pllRefClk,
  output logic slowRcEnable,
  output logic [5:0] fastOscTrim,
  output logic coreClk,
  output logic clockReady,
  output logic clockOutPinO,
  output logic clockOutPinOe_n
);

  initial begin
    if (START_EDGES < 1 || START_EDGES > 65535) begin
      $error("START_EDGES must lie between 1 and 65535");
    end
    if (TUNE_STEP < 1 || TUNE_STEP > 65535) begin
      $error("TUNE_STEP must lie between 1 and 65535");
    end
  end

  localparam int DW = cspc_pkg::DIV_W;
  // Cycles without a change on the half-rate PLL level after which the PLL counts as stopped.
  localparam logic [1:0] PLL_DEAD = 2'h3;

  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_WAIT_OLD_LOW = 2'b01,
    SW_WAIT_NEW_FALL = 2'b10
  } cspc_switch_state_t;

  cspc_pkg::cspc_tune_t tune_r;
  cspc_pkg::cspc_cfg_t cfg_r;
  cspc_pkg::cspc_status_t status;
  cspc_switch_state_t swState_r;
  logic [31:0] prdata_r;
  logic [5:0] trim_r;
  logic [15:0] stepCnt_r;
  logic [15:0] startCnt_r;
  logic ready_r;
  logic sleepPrev_r;
  logic primPrev_r;
  logic pllEnable_r;
  logic slowRcEnable_r;
  logic onPll_r;
  logic target_r;
  logic muxLevel_r;
  logic muxLevel_nxt;
  logic bypassPrev_r;
  logic pllHalfPrev_r;
  logic [1:0] pllIdle_r;
  logic clkOutDrive_r;
  logic clkOutOe_n_r;

  logic setupPhase;
  logic accessWrite;
  logic addrMapped;
  logic pllCapable;
  logic fastOscMode;
  logic internalOnly;
  logic externalMode;
  logic clkOutMode;
  logic primaryLevel;
  logic bypassLevel;
  logic intClkLevel;
  logic postLevel;
  logic lowFreqLevel;
  logic pllHalfLevel;
  logic cpuLevel;
  logic clkOutSrc;
  logic clkOutLevel;
  logic wantPll;
  logic [5:0] trimTarget;

  // Register access over APB: zero wait states, read data captured during the setup cycle.
  assign setupPhase = psel && !penable;
  assign accessWrite = psel && penable && pwrite;
  assign addrMapped = (paddr == cspc_pkg::ADDR_OSC_TUNE) || (paddr == cspc_pkg::ADDR_CLOCK_CONFIG) ||
                      (paddr == cspc_pkg::ADDR_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrMapped;
  assign prdata = prdata_r;

  assign status = '{clockReady: ready_r, slowRcRunning: slowRcEnable_r, coreOnPll: onPll_r,
                    pllLocked: pllLocked, pllRunning: pllEnable_r};

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (setupPhase) begin
      case (paddr)
        cspc_pkg::ADDR_OSC_TUNE: prdata_r <= {24'h00_0000, tune_r};
        cspc_pkg::ADDR_CLOCK_CONFIG: prdata_r <= {17'h0_0000, cfg_r};
        cspc_pkg::ADDR_STATUS: prdata_r <= {27'h000_0000, status};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tune_r <= cspc_pkg::TUNE_RESET;
      cfg_r <= cspc_pkg::CFG_RESET;
    end else if (accessWrite) begin
      if (paddr == cspc_pkg::ADDR_OSC_TUNE) begin
        tune_r <= pwdata[7:0];
      end
      if (paddr == cspc_pkg::ADDR_CLOCK_CONFIG) begin
        cfg_r <= pwdata[14:0];
      end
    end
  end

  // Mode decode.
  assign pllCapable = (cfg_r.oscMode == cspc_pkg::MODE_CRYSTAL_PLL) ||
                      (cfg_r.oscMode == cspc_pkg::MODE_EXT_CLOCK_PLL) ||
                      (cfg_r.oscMode == cspc_pkg::MODE_INT_OSC_PLL) ||
                      (cfg_r.oscMode == cspc_pkg::MODE_INT_OSC_PLL_CLKOUT);
  assign internalOnly = (cfg_r.oscMode == cspc_pkg::MODE_INT_OSC) ||
                        (cfg_r.oscMode == cspc_pkg::MODE_INT_OSC_CLKOUT);
  assign fastOscMode = internalOnly || (cfg_r.oscMode == cspc_pkg::MODE_INT_OSC_PLL) ||
                       (cfg_r.oscMode == cspc_pkg::MODE_INT_OSC_PLL_CLKOUT);
  assign externalMode = (cfg_r.oscMode == cspc_pkg::MODE_EXT_CLOCK) ||
                        (cfg_r.oscMode == cspc_pkg::MODE_EXT_CLOCK_PLL);
  assign clkOutMode = externalMode || (cfg_r.oscMode == cspc_pkg::MODE_INT_OSC_PLL_CLKOUT) ||
                      (cfg_r.oscMode == cspc_pkg::MODE_INT_OSC_CLKOUT);

  // Primary clock
  // External modes take the primary clock from the input pin and trust it to run.
  assign primaryLevel = fastOscMode ? fastOscClk : clockInPin;

  cspc_edge_div #(.DIV_W(DW)) u_postscaler (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .srcLevel(fastOscClk),
    .divisor(cspc_pkg::postDivisor(cfg_r.internalFreqSelect)),
    .divLevel(postLevel)
  );

  cspc_edge_div #(.DIV_W(DW)) u_low_freq_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .srcLevel(fastOscClk),
    .divisor(cspc_pkg::DIV_LOW_FREQ),
    .divLevel(lowFreqLevel)
  );

  always_comb begin
    if (cfg_r.internalFreqSelect == cspc_pkg::FREQ_SEL_DIRECT) begin
      intClkLevel = fastOscClk;
    end else if (cfg_r.internalFreqSelect == cspc_pkg::FREQ_SEL_LOW) begin
      intClkLevel = tune_r.lowFreqSourceSelect ? lowFreqLevel : slowRcClk;
    end else begin
      intClkLevel = postLevel;
    end
  end

  assign bypassLevel = internalOnly ? intClkLevel : primaryLevel;

  cspc_edge_div #(.DIV_W(DW)) u_pll_prescaler (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .srcLevel(primaryLevel),
    .divisor(cspc_pkg::prescaleDivisor(cfg_r.pllPrescaleSelect)),
    .divLevel(pllRefClk)
  );

  cspc_edge_div #(.DIV_W(DW)) u_pll_half (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .srcLevel(pllClk),
    .divisor(cspc_pkg::DIV_PLL_TO_CORE),
    .divLevel(pllHalfLevel)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pllEnable_r <= 1'b0;
    end else begin
      pllEnable_r <= pllCapable && tune_r.pllEnableBit && ready_r;
    end
  end

  assign pllEnable = pllEnable_r;

  // Crystal modes count primary edges before the clock is trusted again after sleep; reset selects an external mode, which is trusted at once.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sleepPrev_r <= 1'b0;
      primPrev_r <= 1'b0;
    end else begin
      sleepPrev_r <= sleepMode;
      primPrev_r <= primaryLevel;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      startCnt_r <= 16'h0000;
      ready_r <= 1'b0;
    end else if (externalMode || fastOscMode) begin
      startCnt_r <= 16'h0000;
      ready_r <= 1'b1;
    end else if (sleepMode || (sleepPrev_r && !sleepMode)) begin
      startCnt_r <= 16'h0000;
      ready_r <= 1'b0;
    end else if (!ready_r && primaryLevel && !primPrev_r) begin
      if (startCnt_r >= 16'(START_EDGES - 1)) begin
        ready_r <= 1'b1;
      end else begin
        startCnt_r <= startCnt_r + 16'h0001;
      end
    end
  end

  assign clockReady = ready_r;

  assign wantPll = pllEnable_r && pllLocked;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bypassPrev_r <= 1'b0;
      pllHalfPrev_r <= 1'b0;
      pllIdle_r <= 2'h0;
    end else begin
      bypassPrev_r <= bypassLevel;
      pllHalfPrev_r <= pllHalfLevel;
      // A disabled PLL may stop with its half-rate level high, which must not hold the switch forever.
      pllIdle_r <= (pllHalfLevel != pllHalfPrev_r) ? 2'h0 : pllIdle_r + {1'b0, pllIdle_r != PLL_DEAD};
    end
  end

  // Glitch-free switch-over
  // The output is parked low once the old clock is low and released only on a falling edge
  // of the new clock, so every phase is at least as long as a full phase of either source.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      swState_r <= SW_IDLE;
      onPll_r <= 1'b0;
      target_r <= 1'b0;
    end else begin
      case (swState_r)
        SW_IDLE: begin
          if (wantPll != onPll_r) begin
            target_r <= wantPll;
            swState_r <= SW_WAIT_OLD_LOW;
          end
        end
        SW_WAIT_OLD_LOW: begin
          if (!muxLevel_r) begin
            swState_r <= SW_WAIT_NEW_FALL;
          end
        end
        SW_WAIT_NEW_FALL: begin
          if (target_r ? (pllHalfPrev_r && !pllHalfLevel) : (bypassPrev_r && !bypassLevel)) begin
            onPll_r <= target_r;
            swState_r <= SW_IDLE;
          end
        end
        default: swState_r <= SW_IDLE;
      endcase
    end
  end

  always_comb begin
    muxLevel_nxt = 1'b0;
    if (!ready_r) begin
      muxLevel_nxt = 1'b0;
    end else if (swState_r == SW_IDLE) begin
      muxLevel_nxt = onPll_r ? pllHalfLevel : bypassLevel;
    end else if (swState_r == SW_WAIT_OLD_LOW) begin
      // Let a high phase of the old clock finish before parking low.
      // A stopped PLL has already stretched this phase, so parking low then shortens nothing.
      muxLevel_nxt = muxLevel_r && (onPll_r ? (pllHalfLevel && pllIdle_r != PLL_DEAD) : bypassLevel);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      muxLevel_r <= 1'b0;
    end else begin
      muxLevel_r <= muxLevel_nxt;
    end
  end

  cspc_edge_div #(.DIV_W(DW)) u_cpu_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .srcLevel(muxLevel_r),
    .divisor(cspc_pkg::cpuDivisor(cfg_r.cpuClockDividerSelect)),
    .divLevel(cpuLevel)
  );

  assign coreClk = cpuLevel;

  always_comb begin
    if (cfg_r.oscMode == cspc_pkg::MODE_EXT_CLOCK) begin
      clkOutSrc = clockInPin;
    end else if (cfg_r.oscMode == cspc_pkg::MODE_EXT_CLOCK_PLL) begin
      clkOutSrc = onPll_r ? pllClk : clockInPin;
    end else begin
      clkOutSrc = muxLevel_r;
    end
  end

  cspc_edge_div #(.DIV_W(DW)) u_clkout_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .srcLevel(clkOutSrc),
    .divisor(cspc_pkg::DIV_CLKOUT),
    .divLevel(clkOutLevel)
  );

  // The clock output holds low in sleep; crystal modes leave the pin to the crystal.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      clkOutDrive_r <= 1'b0;
      clkOutOe_n_r <= 1'b1;
    end else begin
      clkOutDrive_r <= clkOutLevel && !sleepMode;
      clkOutOe_n_r <= !clkOutMode;
    end
  end

  assign clockOutPinO = clkOutDrive_r;
  assign clockOutPinOe_n = clkOutOe_n_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      slowRcEnable_r <= 1'b0;
    end else begin
      slowRcEnable_r <= cfg_r.powerUpTimerEn || cfg_r.failSafeEn || cfg_r.watchdogEn ||
                        cfg_r.twoSpeedEn || (internalOnly && !tune_r.lowFreqSourceSelect &&
                        (cfg_r.internalFreqSelect == cspc_pkg::FREQ_SEL_LOW));
    end
  end

  assign slowRcEnable = slowRcEnable_r;

  // Linear trim code
  // Flipping the sign bit maps 100000 to the lowest code and 011111 to the highest, so the
  // trim code driven to the oscillator is monotonic with equal steps.
  assign trimTarget = tune_r.tuneValue ^ cspc_pkg::TUNE_SIGN_FLIP;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      trim_r <= cspc_pkg::TUNE_SIGN_FLIP;
      stepCnt_r <= 16'h0000;
    end else if (trim_r == trimTarget) begin
      stepCnt_r <= 16'h0000;
    end else if (stepCnt_r >= 16'(TUNE_STEP - 1)) begin
      stepCnt_r <= 16'h0000;
      trim_r <= (trim_r < trimTarget) ? trim_r + 6'h01 : trim_r - 6'h01;
    end else begin
      stepCnt_r <= stepCnt_r + 16'h0001;
    end
  end

  assign fastOscTrim = trim_r;

endmodule
`default_nettype wire

// ==== hdl/cspc_edge_div.sv ====
// Divides a clock level sampled on clk_sys by a run-time divisor, keeping a 50 percent duty cycle.
// Assumes the source level changes at most once per clk_sys cycle.
`timescale 1ns/1ps
`default_nettype none
module cspc_edge_div #(
  parameter int DIV_W = 9
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic srcLevel,
  input wire logic [DIV_W-1:0] divisor,
  output logic divLevel
);

  initial begin
    if (DIV_W < 2) begin
      $error("cspc_edge_div needs DIV_W of at least 2");
    end
  end

  logic srcPrev_r;
  logic divLevel_r;
  logic [DIV_W-1:0] edgeCnt_r;
  logic [DIV_W-1:0] edgeCnt_nxt;

  // Both source edges are counted, so toggling every divisor edges gives a period of divisor
  // source periods; odd divisors keep equal high and low phases this way.
  assign edgeCnt_nxt = edgeCnt_r + {{(DIV_W-1){1'b0}}, 1'b1};

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      srcPrev_r <= 1'b0;
    end else begin
      srcPrev_r <= srcLevel;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      edgeCnt_r <= '0;
      divLevel_r <= 1'b0;
    end else if (srcLevel != srcPrev_r) begin
      if (edgeCnt_nxt >= divisor) begin
        edgeCnt_r <= '0;
        divLevel_r <= ~divLevel_r;
      end else begin
        edgeCnt_r <= edgeCnt_nxt;
      end
    end
  end

  assign divLevel = divLevel_r;

endmodule
`default_nettype wire

// ==== hdl/cspc_pkg.sv ====
// Shared constants, register map and types for the clock source and PLL control block.
// Assumes an APB3 master on clk_sys and oscillator levels already synchronous to clk_sys.
package cspc_pkg;

  localparam logic [11:0] ADDR_OSC_TUNE = 12'h000;
  localparam logic [11:0] ADDR_CLOCK_CONFIG = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  typedef enum logic [2:0] {
    MODE_EXT_CLOCK = 3'b000,
    MODE_EXT_CLOCK_PLL = 3'b001,
    MODE_CRYSTAL = 3'b010,
    MODE_CRYSTAL_PLL = 3'b011,
    MODE_INT_OSC_PLL = 3'b100,
    MODE_INT_OSC_PLL_CLKOUT = 3'b101,
    MODE_INT_OSC = 3'b110,
    MODE_INT_OSC_CLKOUT = 3'b111
  } cspc_osc_mode_t;

  typedef struct packed {
    logic lowFreqSourceSelect;
    logic pllEnableBit;
    logic [5:0] tuneValue;
  } cspc_tune_t;

  typedef struct packed {
    logic twoSpeedEn;
    logic watchdogEn;
    logic failSafeEn;
    logic powerUpTimerEn;
    logic [2:0] internalFreqSelect;
    logic [2:0] pllPrescaleSelect;
    logic [1:0] cpuClockDividerSelect;
    cspc_osc_mode_t oscMode;
  } cspc_cfg_t;

  typedef struct packed {
    logic clockReady;
    logic slowRcRunning;
    logic coreOnPll;
    logic pllLocked;
    logic pllRunning;
  } cspc_status_t;

  localparam cspc_tune_t TUNE_RESET = 8'h00;
  localparam cspc_cfg_t CFG_RESET = 15'h0718;

  localparam int DIV_W = 9;
  localparam logic [DIV_W-1:0] DIV_CLKOUT = 9'h004;
  localparam logic [DIV_W-1:0] DIV_PLL_TO_CORE = 9'h002;
  localparam logic [DIV_W-1:0] DIV_LOW_FREQ = 9'h100;
  localparam logic [2:0] FREQ_SEL_LOW = 3'h0;
  localparam logic [2:0] FREQ_SEL_DIRECT = 3'h7;
  localparam logic [5:0] TUNE_SIGN_FLIP = 6'h20;

  localparam int CLK_SYS_MHZ = 125;
  localparam int TUNE_STEP_NS = 1000;
  localparam int TUNE_STEP_CYCLES = (TUNE_STEP_NS * CLK_SYS_MHZ + 999) / 1000;
  localparam int CRYSTAL_START_EDGES = 1024;

  function automatic logic [DIV_W-1:0] cpuDivisor(input logic [1:0] sel);
    case (sel)
      2'b11: cpuDivisor = 9'h001;
      2'b10: cpuDivisor = 9'h002;
      2'b01: cpuDivisor = 9'h003;
      default: cpuDivisor = 9'h006;
    endcase
  endfunction

  function automatic logic [DIV_W-1:0] prescaleDivisor(input logic [2:0] sel);
    case (sel)
      3'b000: prescaleDivisor = 9'h00C;
      3'b001: prescaleDivisor = 9'h00A;
      3'b010: prescaleDivisor = 9'h006;
      3'b011: prescaleDivisor = 9'h005;
      3'b100: prescaleDivisor = 9'h004;
      3'b101: prescaleDivisor = 9'h003;
      3'b110: prescaleDivisor = 9'h002;
      default: prescaleDivisor = 9'h001;
    endcase
  endfunction

  function automatic logic [DIV_W-1:0] postDivisor(input logic [2:0] sel);
    postDivisor = 9'h001 << (3'h7 - sel);
  endfunction

endpackage

// ==== tb/cspc_clock_control_monitor.sv ====
// Concurrent checks on the clock control block, bound to its ports.
// Assumes APB writes land when psel, penable and pready are high together.
`timescale 1ns/1ps
`default_nettype none
module cspc_clock_control_monitor #(
  parameter int TUNE_STEP = 2
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pllEnable,
  input wire logic slowRcEnable,
  input wire logic [5:0] fastOscTrim,
  input wire logic coreClk,
  input wire logic clockReady,
  input wire logic clockOutPinOe_n
);
  logic [14:0] cfgCopy_r;
  logic [7:0] tuneCopy_r;
  logic wrDone;
  logic pllBit;
  logic capMode;
  logic oeMode;
  logic extMode;
  logic supEn;
  logic [5:0] trimGoal;
  assign wrDone = psel && penable && pwrite && pready;
  assign pllBit = tuneCopy_r[6];
  assign capMode = cfgCopy_r[2:0] inside {3'h1, 3'h3, 3'h4, 3'h5};
  assign oeMode = cfgCopy_r[2:0] inside {3'h0, 3'h1, 3'h5, 3'h7};
  assign extMode = cfgCopy_r[2:1] == 2'h0;
  assign supEn = |cfgCopy_r[14:11];
  assign trimGoal = tuneCopy_r[5:0] ^ 6'h20;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) cfgCopy_r <= cspc_pkg::CFG_RESET;
    else if (wrDone && paddr == cspc_pkg::ADDR_CLOCK_CONFIG) cfgCopy_r <= pwdata[14:0];
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) tuneCopy_r <= cspc_pkg::TUNE_RESET;
    else if (wrDone && paddr == cspc_pkg::ADDR_OSC_TUNE) tuneCopy_r <= pwdata[7:0];
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_pll_bit; pllEnable |-> $past(pllBit); endproperty
  a_pll_bit: assert property (p_pll_bit) else $error("PLL enabled without its enable bit");
  property p_pll_mode; pllEnable |-> $past(capMode); endproperty
  a_pll_mode: assert property (p_pll_mode) else $error("PLL enabled in a mode without PLL");
  property p_oe_ext; oeMode[*3] |-> !clockOutPinOe_n; endproperty
  a_oe_ext: assert property (p_oe_ext) else $error("Clock output not driven in a clock out mode");
  property p_ready_ext; extMode[*3] |-> clockReady; endproperty
  a_ready_ext: assert property (p_ready_ext) else $error("External clock not ready at once");
  property p_slow_rc; supEn[*3] |-> slowRcEnable; endproperty
  a_slow_rc: assert property (p_slow_rc) else $error("Slow RC off while a supervisor needs it");
  property p_trim_step;
    $changed(fastOscTrim) |-> fastOscTrim == $past(fastOscTrim) + 6'h01 || fastOscTrim == $past(fastOscTrim) - 6'h01;
  endproperty
  a_trim_step: assert property (p_trim_step) else $error("Trim moved by more than one code");
  property p_trim_pace; $changed(fastOscTrim) |=> $stable(fastOscTrim); endproperty
  a_trim_pace: assert property (p_trim_pace) else $error("Trim stepped faster than its pace");
  property p_trim_moves; not ((fastOscTrim != trimGoal && $stable(fastOscTrim))[*6]); endproperty
  a_trim_moves: assert property (p_trim_moves) else $error("Trim stalled short of its target");
  property p_no_glitch; $changed(coreClk) |=> $stable(coreClk); endproperty
  a_no_glitch: assert property (p_no_glitch) else $error("Core clock phase of one cycle");
  c_pll_on: cover property ($rose(pllEnable));
  c_trim_move: cover property ($changed(fastOscTrim));
  c_slow_on: cover property ($rose(slowRcEnable));
endmodule
bind cspc_clock_control cspc_clock_control_monitor #(.TUNE_STEP(TUNE_STEP)) cspc_clock_control_monitor_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pllEnable(pllEnable), .slowRcEnable(slowRcEnable),
  .fastOscTrim(fastOscTrim), .coreClk(coreClk), .clockReady(clockReady), .clockOutPinOe_n(clockOutPinOe_n)
);
`default_nettype wire

// ==== tb/cspc_clock_control_tb.sv ====
// Self-checking bench for the clock control block: register traffic and clock ratio counts.
// Assumes the oscillator model drives every clock level on clk_sys edges.
`timescale 1ns/1ps
`default_nettype none
`define CSPC_CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_errors++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module cspc_clock_control_tb;
  typedef struct {string nm; logic [32:0] ex; bit tol;} cspc_exp_t;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic sleepMode = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, pllEnable, pllRefClk, slowRcEnable, coreClk, clockReady, clockOutPinO, clockOutPinOe_n;
  logic clockInPin, fastOscClk, slowRcClk, pllClk, pllLocked;
  logic [5:0] fastOscTrim;
  logic [31:0] measVal = 32'h0;
  logic measDone = 1'b0;
  wire [2:0] probe = {pllRefClk, clockOutPinO, coreClk};
  cspc_exp_t expQ[$];
  int n_errors = 0;
  int samples_checked = 0;
  int seed = 98;
  always #4 clk_sys = ~clk_sys;
  cspc_clock_control #(.START_EDGES(4), .TUNE_STEP(2)) cspc_clock_control_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .clockInPin(clockInPin),
    .fastOscClk(fastOscClk), .slowRcClk(slowRcClk), .pllClk(pllClk), .pllLocked(pllLocked),
    .sleepMode(sleepMode), .pllEnable(pllEnable), .pllRefClk(pllRefClk), .slowRcEnable(slowRcEnable),
    .fastOscTrim(fastOscTrim), .coreClk(coreClk), .clockReady(clockReady), .clockOutPinO(clockOutPinO),
    .clockOutPinOe_n(clockOutPinOe_n)
  );
  cspc_osc_model cspc_osc_model_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .pllEnable(pllEnable), .slowRcEnable(slowRcEnable),
    .clockInPin(clockInPin), .fastOscClk(fastOscClk), .slowRcClk(slowRcClk), .pllClk(pllClk),
    .pllLocked(pllLocked)
  );
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // The first edge wait keeps one idle cycle between transfers, so psel is never assigned twice at one edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] ex,
                     input string nm);
    int t;
    @(posedge clk_sys);
    if (!wr) expQ.push_back('{nm, ex, 1'b0});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic post(input string nm, input logic [31:0] ex, input logic [31:0] val, input bit tol);
    expQ.push_back('{nm, {1'b0, ex}, tol});
    measVal <= val;
    measDone <= 1'b1;
    @(posedge clk_sys);
    measDone <= 1'b0;
  endtask
  // Toggle counts allow two of slack for the phase in flight when a setting changes.
  task automatic measure(input string nm, input int sel, input int cyc, input int ex);
    int n;
    logic p;
    n = 0;
    p = probe[sel];
    repeat (cyc) begin
      @(posedge clk_sys);
      if (probe[sel] !== p) n++;
      p = probe[sel];
    end
    post(nm, ex, n, 1'b1);
  endtask
  always @(posedge clk_sys) begin
    cspc_exp_t e;
    logic [32:0] got;
    if ((psel && penable && pready && !pwrite) || measDone) begin
      got = measDone ? {1'b0, measVal} : {pslverr, prdata};
      e = expQ.pop_front();
      if (e.tol && got <= e.ex + 33'h2 && got + 33'h2 >= e.ex) got = e.ex;
      `CSPC_CHK(e.nm, e.ex, got)
    end
  end
  function automatic logic [31:0] cfgw(input logic [2:0] m, input logic [1:0] cd, input logic [2:0] pre,
                                       input logic [2:0] fs, input logic [3:0] sup);
    cfgw = {17'h0, sup, fs, pre, cd, m};
  endfunction
  initial begin
    int dv[4];
    int pr[8];
    int fsel[6];
    int fexp[6];
    logic [5:0] t;
    dv = '{6, 3, 2, 1};
    pr = '{12, 10, 6, 5, 4, 3, 2, 1};
    fsel = '{7, 6, 4, 1, 0, 0};
    fexp = '{2048, 1024, 256, 32, 64, 8};
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, 33'h0, "tune reset");
    apb(1'b0, 12'h004, 32'h0, 33'h718, "config reset");
    apb(1'b0, 12'h008, 32'h0, 33'h10, "status reset");
    apb(1'b0, 12'h00C, 32'h0, 33'h100000000, "unmapped read");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h004, cfgw(3'h0, 2'(i), 3'h0, 3'h7, 4'h0), 33'h0, "");
      measure("core divider", 0, 720, 240 / dv[i]);
    end
    measure("clock out ext", 1, 720, 60);
    sleepMode <= 1'b1;
    measure("clock out sleep", 1, 240, 0);
    sleepMode <= 1'b0;
    apb(1'b1, 12'h004, cfgw(3'h2, 2'h3, 3'h0, 3'h7, 4'h0), 33'h0, "");
    apb(1'b1, 12'h000, 32'h40, 33'h0, "");
    apb(1'b0, 12'h008, 32'h0, 33'h10, "status no pll");
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 12'h004, cfgw(3'h1, 2'h3, 3'(i), 3'h7, 4'h0), 33'h0, "");
      measure("prescaler", 2, 720, 240 / pr[i]);
    end
    measure("clock out pll", 1, 720, 180);
    measure("core on pll", 0, 720, 360);
    apb(1'b0, 12'h008, 32'h0, 33'h17, "status locked");
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 12'h000, {24'h0, i == 5, 7'h40}, 33'h0, "");
      apb(1'b1, 12'h004, cfgw(3'h6, 2'h3, 3'h0, 3'(fsel[i]), 4'h0), 33'h0, "");
      measure("internal clock", 0, 4096, fexp[i]);
    end
    apb(1'b0, 12'h008, 32'h0, 33'h10, "status int osc");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h004, cfgw(3'h6, 2'h3, 3'h0, 3'h7, 4'(1 << i)), 33'h0, "");
      apb(1'b0, 12'h008, 32'h0, 33'h18, "status slow rc");
    end
    for (int i = 0; i < 5; i++) begin
      t = (i == 0) ? 6'h1F : (i == 1) ? 6'h20 : 6'($random(seed));
      apb(1'b1, 12'h000, {26'h0, t}, 33'h0, "");
      repeat (140) @(posedge clk_sys);
      post("trim", {26'h0, t ^ 6'h20}, {26'h0, fastOscTrim}, 1'b0);
      apb(1'b0, 12'h000, 32'h0, {27'h0, t}, "tune read");
    end
    repeat (4) @(posedge clk_sys);
    finish_test();
  end
endmodule
`default_nettype wire

// ==== tb/cspc_osc_model.sv ====
// Behavioural external clock source, internal oscillators and PLL around the clock control block.
// Assumes every level may change on clk_sys edges only, as the block samples them synchronously.
`timescale 1ns/1ps
`default_nettype none
module cspc_osc_model #(
  parameter int EXT_HALF = 3,
  parameter int FAST_HALF = 2,
  parameter int SLOW_HALF = 64,
  parameter int LOCK_CYCLES = 40
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pllEnable,
  input wire logic slowRcEnable,
  output logic clockInPin,
  output logic fastOscClk,
  output logic slowRcClk,
  output logic pllClk,
  output logic pllLocked
);
  int extCnt = 0;
  int fastCnt = 0;
  int slowCnt = 0;
  int lockCnt = 0;
  initial begin
    clockInPin = 1'b0;
    fastOscClk = 1'b0;
    slowRcClk = 1'b0;
    pllClk = 1'b0;
    pllLocked = 1'b0;
  end
  // external clock and fast internal oscillator supplied.
  // The source runs free through reset, like a board oscillator.
  always @(posedge clk_sys) begin
    extCnt <= (extCnt == EXT_HALF - 1) ? 0 : extCnt + 1;
    if (extCnt == EXT_HALF - 1) clockInPin <= ~clockInPin;
    fastCnt <= (fastCnt == FAST_HALF - 1) ? 0 : fastCnt + 1;
    if (fastCnt == FAST_HALF - 1) fastOscClk <= ~fastOscClk;
  end
  // The slow RC and the PLL stand still while not enabled, so a missing enable shows up as a dead clock.
  always @(posedge clk_sys) begin
    slowCnt <= (!slowRcEnable || slowCnt == SLOW_HALF - 1) ? 0 : slowCnt + 1;
    if (slowRcEnable && slowCnt == SLOW_HALF - 1) slowRcClk <= ~slowRcClk;
    pllClk <= pllEnable ? ~pllClk : 1'b0;
    lockCnt <= (!rst_n || !pllEnable) ? 0 : (lockCnt < LOCK_CYCLES ? lockCnt + 1 : lockCnt);
    pllLocked <= rst_n && pllEnable && lockCnt == LOCK_CYCLES;
  end
endmodule
`default_nettype wire
